/* design/tcs_clock_control.sv */
// Purpose: clock gates, oscillator setup, timer kernel clock select
// Assumes: apb slave, zero wait states, one clock domain
// Notes:   timer-6 register window is only decoded here
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "tcs_params.svh"

module tcs_clock_control
    import tcs_pkg::*;
#(
    parameter int NUM_TIM = 8
) (
    // clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 arst_n_in,
    // apb slave
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [31:0]          paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    // timer-6 register window select
    output logic                      tim6_window_sel_out,
    // module clock gates
    output logic      [31:0]          periph_clk_gate_out,
    // oscillator controls
    output tcs_osc_ctrl_t             osc_ctrl_out,
    // timer kernel clocks
    output logic      [2*NUM_TIM-1:0] timer_clk_sel_out,
    output logic      [NUM_TIM-1:0]   timer_clk_gate_out
);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    localparam int HOLD = `TCS_SW_HOLD_CYC;
    localparam int SW_WIN = 2 * HOLD + 2;

    logic [31:0] gate_ff;
    logic [31:0] ana_ff;
    logic [31:0] tsel_ff;
    logic [31:0] rdy_word;
    logic [31:0] nxt_rdata;
    logic [31:0] prdata_ff;
    logic        sys_hit;
    logic        tim6_hit;
    logic        reg_hit;
    logic        wr_go;
    logic        rd_setup;
    logic [7:0]  off;

    assign off = paddr_in[7:0];
    assign sys_hit = (paddr_in[`TCS_PAGE_MSB:`TCS_PAGE_LSB] ==
                      24'(`TCS_SYS_BASE >> `TCS_PAGE_LSB));
    assign tim6_hit = (paddr_in[`TCS_PAGE_MSB:`TCS_PAGE_LSB] ==
                       24'(`TCS_TIM6_BASE >> `TCS_PAGE_LSB));

    always_comb begin
        reg_hit = 1'b0;
        if (sys_hit) begin
            case (off)
                `TCS_OFF_GATE: reg_hit = 1'b1;
                `TCS_OFF_ANA:  reg_hit = 1'b1;
                `TCS_OFF_TSEL: reg_hit = 1'b1;
                `TCS_OFF_RDY:  reg_hit = 1'b1;
                default:       reg_hit = 1'b0;
            endcase
        end
    end

    // zero wait states; timer-6 window is refused here with pslverr and flagged on its select output
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~reg_hit;
    assign tim6_window_sel_out = psel_in & tim6_hit;
    assign wr_go = psel_in & penable_in & pwrite_in & reg_hit;
    assign rd_setup = psel_in & ~penable_in & ~pwrite_in;

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gate_ff <= `TCS_GATE_RST;
        end else if (wr_go && off == `TCS_OFF_GATE) begin
            gate_ff <= pwdata_in & `TCS_GATE_WMASK;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ana_ff <= `TCS_ANA_RST;
        end else if (wr_go && off == `TCS_OFF_ANA) begin
            ana_ff <= pwdata_in & `TCS_ANA_WMASK;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tsel_ff <= `TCS_TSEL_RST;
        end else if (wr_go && off == `TCS_OFF_TSEL) begin
            tsel_ff <= 32'(pwdata_in[2*NUM_TIM-1:0]);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (sys_hit) begin
            case (off)
                `TCS_OFF_GATE: nxt_rdata = gate_ff;
                `TCS_OFF_ANA:  nxt_rdata = ana_ff;
                `TCS_OFF_TSEL: nxt_rdata = tsel_ff;
                `TCS_OFF_RDY:  nxt_rdata = rdy_word;
                default:       nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // captured in the setup cycle so the access phase sees a flop
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= nxt_rdata;
        end
    end

    assign prdata_out = prdata_ff;

    // ----------------------------------------------------------------
    // clock gates and oscillator
    // ----------------------------------------------------------------
    assign periph_clk_gate_out = gate_ff;

    logic [1:0] act_path;
    logic [1:0] pas_path;

    assign act_path = ana_ff[`TCS_F_ACT_LSB +: 2];
    assign pas_path = ana_ff[`TCS_F_PAS_LSB +: 2];

    always_comb begin
        osc_ctrl_out.drive_high = ana_ff[`TCS_B_DRIVE];
        osc_ctrl_out.freq_class = ana_ff[`TCS_B_FCLASS];
        osc_ctrl_out.active_path = act_path;
        // an active oscillator always wins over the crystal circuit
        if (act_path != 2'b00) begin
            osc_ctrl_out.passive_path = 2'b00;
            osc_ctrl_out.passive_power = 1'b0;
        end else begin
            osc_ctrl_out.passive_path = pas_path;
            osc_ctrl_out.passive_power = (pas_path != 2'b00);
        end
    end

    // ----------------------------------------------------------------
    // glitch-free kernel clock switching
    // ----------------------------------------------------------------
    // the gate is dropped before the mux moves and raised only after
    // the new source has settled, so no runt pulse reaches a timer
    logic [NUM_TIM-1:0] sw_rdy;
    logic [NUM_TIM-1:0] tsel_write;

    assign tsel_write = {NUM_TIM{wr_go && off == `TCS_OFF_TSEL}};

    for (genvar i = 0; i < NUM_TIM; i++) begin : g_sw
        tcs_sw_state_t state_ff;
        logic [3:0]    cnt_ff;
        logic [1:0]    live_ff;
        logic          gate_on_ff;
        logic          rdy_ff;
        logic          change;

        assign change = tsel_write[i] &&
                        (pwdata_in[2*i +: 2] != tsel_ff[2*i +: 2]);

        always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                state_ff <= TCS_SW_IDLE;
                cnt_ff <= 4'h0;
                live_ff <= TCS_SRC_PLL;
                gate_on_ff <= 1'b1;
                rdy_ff <= 1'b1;
            end else if (change) begin
                // a new request restarts the sequence from the drain step
                state_ff <= TCS_SW_DRAIN;
                cnt_ff <= 4'(HOLD - 1);
                gate_on_ff <= 1'b0;
                rdy_ff <= 1'b0;
            end else begin
                case (state_ff)
                    TCS_SW_IDLE: begin
                        cnt_ff <= 4'h0;
                    end
                    TCS_SW_DRAIN: begin
                        if (cnt_ff == 4'h0) begin
                            live_ff <= tsel_ff[2*i +: 2];
                            cnt_ff <= 4'(HOLD - 1);
                            state_ff <= TCS_SW_SETTLE;
                        end else begin
                            cnt_ff <= cnt_ff - 4'h1;
                        end
                    end
                    TCS_SW_SETTLE: begin
                        if (cnt_ff == 4'h0) begin
                            gate_on_ff <= 1'b1;
                            rdy_ff <= 1'b1;
                            state_ff <= TCS_SW_IDLE;
                        end else begin
                            cnt_ff <= cnt_ff - 4'h1;
                        end
                    end
                    default: begin
                        state_ff <= TCS_SW_IDLE;
                    end
                endcase
            end
        end

        assign timer_clk_sel_out[2*i +: 2] = live_ff;
        assign timer_clk_gate_out[i] = gate_on_ff;
        assign sw_rdy[i] = rdy_ff;
    end

    // pwm flags never switch in this block and stay complete
    assign rdy_word = 32'({sw_rdy, 2'b11});

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic rdy6;
    logic gw;
    logic aw;
    logic sw;

    assign rdy6 = sw_rdy[6];
    assign gw = wr_go && off == `TCS_OFF_GATE;
    assign aw = wr_go && off == `TCS_OFF_ANA;
    assign sw = wr_go && off == `TCS_OFF_TSEL;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_t6_change;
        sw && pwdata_in[13:12] != tsel_ff[13:12];
    endsequence

    sequence s_t6_wait;
        !rdy6 [*8] ##1 rdy6;
    endsequence

    sequence s_t6_gate_wait;
        !timer_clk_gate_out[6] [*8] ##1 timer_clk_gate_out[6];
    endsequence

    a_tim6_gate: assert property (
        gw |=> periph_clk_gate_out[17] == $past(pwdata_in[17]))
        else $error("timer-6 clock enable not written");

    a_port_gates: assert property (
        gw |=> periph_clk_gate_out[25:23] == $past(pwdata_in[25:23]))
        else $error("port clock enables not written");

    a_dma_gate: assert property (
        gw |=> periph_clk_gate_out[22] == $past(pwdata_in[22]))
        else $error("dma clock enable not written");

    a_gate_offset: assert property (
        rd_setup && sys_hit && off == 8'h04 |=> prdata_out == gate_ff)
        else $error("gate register not read at its offset");

    a_osc_fields: assert property (
        aw |=> osc_ctrl_out.drive_high == $past(pwdata_in[5]) &&
               osc_ctrl_out.freq_class == $past(pwdata_in[4]))
        else $error("oscillator drive or class not written");

    a_active_path: assert property (
        aw |=> osc_ctrl_out.active_path == $past(pwdata_in[3:2]))
        else $error("active path not written");

    a_passive_off: assert property (
        osc_ctrl_out.active_path != 2'b00 |->
            !osc_ctrl_out.passive_power && osc_ctrl_out.passive_path == 2'b00)
        else $error("passive circuit on with active path");

    a_passive_power: assert property (
        aw && pwdata_in[3:2] == 2'b00 && pwdata_in[1:0] != 2'b00
            |=> osc_ctrl_out.passive_power)
        else $error("passive circuit not powered");

    a_sel_write: assert property (
        sw |=> tsel_ff[15:0] == $past(pwdata_in[15:0]))
        else $error("select register not written");

    a_switch_flag: assert property (
        s_t6_change |=> !rdy6 && !timer_clk_gate_out[6])
        else $error("switch flag sequence broken");

    a_switch_seq: assert property (
        s_t6_change |=> s_t6_wait)
        else $error("timer-6 flag not low for the switch time");

    a_src_live: assert property (
        rdy6 |-> timer_clk_sel_out[13:12] == tsel_ff[13:12])
        else $error("timer-6 source differs from select when done");

    a_gate_off: assert property (
        !rdy6 |-> !timer_clk_gate_out[6])
        else $error("timer-6 clock gated on during switch");

    a_switch_bound: assert property (
        $fell(rdy6) |-> ##[1:SW_WIN] rdy6 || sw)
        else $error("switch did not finish in time");

    a_rdy_upper: assert property (
        rd_setup && sys_hit && off == 8'h48 |=> prdata_out[31:10] == 22'h00_0000 &&
            prdata_out[8] == $past(rdy6))
        else $error("status register bits wrong");

    a_unmapped: assert property (
        psel_in && penable_in && !sys_hit |-> pslverr_out)
        else $error("unmapped access not refused");

    a_write_refused: assert property (
        psel_in && penable_in && pwrite_in && !reg_hit |=> $stable(gate_ff) && $stable(ana_ff) && $stable(tsel_ff))
        else $error("refused write changed a register");

    a_gate_reserved: assert property (
        gw |=> periph_clk_gate_out[31:27] == 5'h00)
        else $error("reserved gate bits written");

    a_ana_offset: assert property (
        rd_setup && sys_hit && off == `TCS_OFF_ANA |=> prdata_out == ana_ff)
        else $error("analog register not read at its offset");

    a_sel_offset: assert property (
        rd_setup && sys_hit && off == `TCS_OFF_TSEL |=> prdata_out == tsel_ff)
        else $error("select register not read at its offset");

    a_passive_path: assert property (
        aw && pwdata_in[3:2] == 2'b00 |=> osc_ctrl_out.passive_path == $past(pwdata_in[1:0]))
        else $error("passive path not written");

    // the mux must not move until the drain step has run out
    a_src_hold: assert property (
        s_t6_change |=> $stable(timer_clk_sel_out[13:12]) [*4])
        else $error("timer-6 source moved before drain ended");

    a_gate_wait: assert property (
        s_t6_change |=> s_t6_gate_wait)
        else $error("timer-6 gate not off for the switch time");

    a_pwm_flags: assert property (
        rd_setup && sys_hit && off == `TCS_OFF_RDY |=> prdata_out[1:0] == 2'b11)
        else $error("pwm switch flags not complete");

endmodule

/* inc/tcs_params.svh */
// Purpose: register map, field positions, reset values, timing
// Assumes: 32-bit apb data, byte addresses
// Notes:   included by the design file and the testbench
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
`define TCS_SYS_BASE       32'h5000_0000
`define TCS_TIM6_BASE      32'h5006_0600
`define TCS_PAGE_MSB       31
`define TCS_PAGE_LSB       8
`define TCS_OFF_GATE       8'h04
`define TCS_OFF_ANA        8'h10
`define TCS_OFF_TSEL       8'h44
`define TCS_OFF_RDY        8'h48

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define TCS_GATE_RST       32'h0000_0001
`define TCS_GATE_WMASK     32'h07ff_ffff
`define TCS_ANA_RST        32'h0000_1850
`define TCS_ANA_WMASK      32'h0000_1fff
`define TCS_TSEL_RST       32'h0000_0000
`define TCS_RDY_RST        32'h0000_03ff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCS_B_TIMER6_MODULE_ENABLE      17
`define TCS_B_DMA_EN       22
`define TCS_B_PORTA_EN     23
`define TCS_B_PORTB_EN     24
`define TCS_B_PORTC_EN     25
`define TCS_B_PORTD_EN     26
`define TCS_B_DRIVE        5
`define TCS_B_FCLASS       4
`define TCS_F_ACT_LSB      2
`define TCS_F_PAS_LSB      0
`define TCS_RDY_TIM_LSB    2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TCS_CLK_PERIOD_NS  10
`define TCS_SW_HOLD_NS     40
`define TCS_SW_HOLD_CYC    ((`TCS_SW_HOLD_NS + `TCS_CLK_PERIOD_NS - 1) / `TCS_CLK_PERIOD_NS)

`endif

/* inc/tcs_pkg.sv */
// Purpose: shared types of the timer clock source control
// Assumes: tcs_params.svh holds the numbers
// Notes:   types only
package tcs_pkg;

    // per-timer switch sequence
    typedef enum logic [1:0] {
        TCS_SW_IDLE,
        TCS_SW_DRAIN,
        TCS_SW_SETTLE
    } tcs_sw_state_t;

    // oscillator controls towards the analog front end
    typedef struct packed {
        logic       drive_high;
        logic       freq_class;
        logic [1:0] active_path;
        logic [1:0] passive_path;
        logic       passive_power;
    } tcs_osc_ctrl_t;

    // kernel clock source codes
    typedef enum logic [1:0] {
        TCS_SRC_PLL,
        TCS_SRC_LRC,
        TCS_SRC_XTAL,
        TCS_SRC_XTAL_ALT
    } tcs_src_t;

endpackage

/* testbench/timer_clock_source_control_test.sv */
// Purpose: self-checking bench for the timer clock source control block
// Assumes: apb master driven on rising edges, zero-wait slave, 100 mhz clock
// Notes:   each scenario is its own task and judges its own results
`timescale 1ns/1ps
`include "tcs_params.svh"

module timer_clock_source_control_test
    import tcs_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic          ref_clk;
    logic          arst_n;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [31:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          win_sel;
    logic [31:0]   gate;
    tcs_osc_ctrl_t osc;
    logic [15:0]   tsel;
    logic [7:0]    tgate;
    int            bad_count;
    int            n_tests;

    tcs_clock_control #(.NUM_TIM(8)) uut (
        .ref_clk_in          (ref_clk),
        .arst_n_in           (arst_n),
        .psel_in             (psel),
        .penable_in          (penable),
        .pwrite_in           (pwrite),
        .paddr_in            (paddr),
        .pwdata_in           (pwdata),
        .prdata_out          (prdata),
        .pready_out          (pready),
        .pslverr_out         (pslverr),
        .tim6_window_sel_out (win_sel),
        .periph_clk_gate_out (gate),
        .osc_ctrl_out        (osc),
        .timer_clk_sel_out   (tsel),
        .timer_clk_gate_out  (tgate)
    );

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // holds the request until pready is sampled high, takes data at that edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready wait", 32'h1, 32'h0);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_ok(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
        chk("write error flag", 32'h0, {31'h0, e});
    endtask

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(what, exp, rd);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk("gate reset", `TCS_SYS_BASE + 32'h04, 32'h0000_0001);
        rd_chk("analog reset", `TCS_SYS_BASE + 32'h10, 32'h0000_1850);
        rd_chk("select reset", `TCS_SYS_BASE + 32'h44, 32'h0000_0000);
        rd_chk("flags reset", `TCS_SYS_BASE + 32'h48, 32'h0000_03ff);
        chk("class reset", 32'h1, {31'h0, osc.freq_class});
        chk("passive off at reset", 32'h0, {31'h0, osc.passive_power});
        chk("sources at reset", 32'h0, {16'h0, tsel});
        chk("gates at reset", 32'h0000_00ff, {24'h0, tgate});
        $display("test reset values done");
    endtask

    task automatic t_gate();
        int bits[6] = '{17, 22, 23, 24, 25, 26};
        logic [31:0] rd;
        logic        e;
        // timer divisions live in the timer window; a write there before its enable is refused
        apb(1'b1, `TCS_TIM6_BASE, 32'h0, rd, e);
        chk("timer6 window refused", 32'h1, {31'h0, e});
        wr_ok(`TCS_SYS_BASE + 32'h04, 32'hffff_ffff);
        rd_chk("gate all ones", `TCS_SYS_BASE + 32'h04, 32'h07ff_ffff);
        foreach (bits[i]) begin
            wr_ok(`TCS_SYS_BASE + 32'h04, 32'h1 << bits[i]);
            @(negedge ref_clk);
            chk("gate one hot out", 32'h1 << bits[i], gate);
        end
        wr_ok(`TCS_SYS_BASE + 32'h04, 32'h0);
        @(negedge ref_clk);
        chk("gate all off", 32'h0, gate);
        wr_ok(`TCS_SYS_BASE + 32'h04, 32'h1);
        $display("test clock gates done");
    endtask

    task automatic t_osc();
        logic [31:0] v;
        logic        pw;
        for (int i = 0; i < 16; i++) begin
            v  = 32'h0000_1800 | (32'(i & 1) << 5) | (32'((i >> 1) & 1) << 4) | 32'(i);
            pw = ((i >> 2) == 0) && ((i & 3) != 0);
            wr_ok(`TCS_SYS_BASE + 32'h10, v);
            @(negedge ref_clk);
            chk("drive select", {31'h0, v[5]}, {31'h0, osc.drive_high});
            chk("class select", {31'h0, v[4]}, {31'h0, osc.freq_class});
            chk("active path", {30'h0, v[3:2]}, {30'h0, osc.active_path});
            chk("passive path", (v[3:2] != 2'b00) ? 32'h0 : {30'h0, v[1:0]}, {30'h0, osc.passive_path});
            chk("passive power", {31'h0, pw}, {31'h0, osc.passive_power});
            rd_chk("analog readback", `TCS_SYS_BASE + 32'h10, v);
        end
        // leave a crystal source behind: passive path a, active off
        wr_ok(`TCS_SYS_BASE + 32'h10, 32'h0000_1851);
        $display("test oscillator setup done");
    endtask

    task automatic t_switch();
        logic [1:0] codes[4] = '{2'b01, 2'b10, 2'b11, 2'b00};
        logic [1:0] prev;
        prev = 2'b00;
        foreach (codes[i]) begin
            wr_ok(`TCS_SYS_BASE + 32'h44, {18'h0, codes[i], 12'h0});
            @(negedge ref_clk);
            @(negedge ref_clk);
            chk("timer6 gate during switch", 32'h0, {31'h0, tgate[6]});
            chk("old source held", {30'h0, prev}, {30'h0, tsel[13:12]});
            rd_chk("flag low in switch", `TCS_SYS_BASE + 32'h48, 32'h0000_02ff);
            repeat (12) @(negedge ref_clk);
            chk("new source applied", {30'h0, codes[i]}, {30'h0, tsel[13:12]});
            chk("timer6 gate back", 32'h1, {31'h0, tgate[6]});
            rd_chk("flag high after", `TCS_SYS_BASE + 32'h48, 32'h0000_03ff);
            rd_chk("select readback", `TCS_SYS_BASE + 32'h44, {18'h0, codes[i], 12'h0});
            prev = codes[i];
        end
        $display("test timer6 source switch done");
    endtask

    task automatic t_decode();
        logic [31:0] rd;
        logic        e;
        apb(1'b0, `TCS_SYS_BASE + 32'h20, 32'h0, rd, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 32'h5100_0004, 32'h0, rd, e);
        chk("other base error", 32'h1, {31'h0, e});
        rd_chk("gate untouched", `TCS_SYS_BASE + 32'h04, 32'h0000_0001);
        wr_ok(`TCS_SYS_BASE + 32'h48, 32'h0);
        rd_chk("flags read only", `TCS_SYS_BASE + 32'h48, 32'h0000_03ff);
        @(posedge ref_clk);
        psel  <= 1'b1;
        paddr <= `TCS_TIM6_BASE;
        @(negedge ref_clk);
        chk("timer6 window select", 32'h1, {31'h0, win_sel});
        @(posedge ref_clk);
        penable <= 1'b1;
        @(negedge ref_clk);
        chk("timer6 window error", 32'h1, {31'h0, pslverr});
        @(posedge ref_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge ref_clk);
        chk("timer6 window idle", 32'h0, {31'h0, win_sel});
        $display("test address decode done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        bad_count = 0;
        n_tests   = 0;
        arst_n    = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 32'h0;
        pwdata    = 32'h0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_gate();
        t_osc();
        t_switch();
        t_decode();
        tally_and_finish();
    end

    // whole run needs about three hundred cycles; allow over sixty times that
    initial begin
        #200us;
        bad_count++;
        tally_and_finish();
    end
endmodule
